// ---- rtl/tlsf_pkg.sv ----
// package for the temperature limit status flags block
// assumes a two-wire bus engine outside that turns bus cycles into
// pointer-addressed register strobes on the device clock
`default_nettype none
package tlsf_pkg;
  // register pointers
  localparam logic [7:0] PTR_SOFT_RESET_CONTROL = 8'h20;
  localparam logic [7:0] PTR_FIRST_LIMIT_FLAGS = 8'h21;
  localparam logic [7:0] PTR_SECOND_LIMIT_FLAGS = 8'h22;
  localparam logic [7:0] PTR_REMOTE_OPEN_FLAGS = 8'h23;
  // field positions and reset values
  localparam int SOFT_RESET_BIT = 15;
  localparam int FLAG_LSB = 7;
  localparam int OPEN_LSB = 8;
  localparam logic [15:0] SOFT_RESET_POR = 16'h0000;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;
  localparam int NUM_CHAN = 9;
  localparam logic [3:0] LOCAL_CHAN = 4'h0;

  // one register access from the bus engine
  typedef struct packed {
    logic wrStrobe;
    logic rdStrobe;
    logic [7:0] pointer;
    logic [15:0] wdata;
  } tlsf_reg_req_t;

  // one stored conversion result
  typedef struct packed {
    logic valid;
    logic [3:0] chan;
    logic [15:0] temp;
    logic open;
  } tlsf_conv_t;
endpackage
`default_nettype wire

// ---- rtl/tlsf_status_flags.sv ----
// limit comparators, status flags, alert outputs and software reset
// assumes limits, hysteresis, lock state and conversion results come
// from logic on the same clock, so no input is synchronised
`default_nettype none
// What this block does
// - soft reset register sits at pointer 20h, read/write, powers up zero
// - writing one to bit 15 resets device registers; bits 14-0 read zero
// - while registers are locked, a soft reset write is ignored
// - first-limit flags register at pointer 21h is read-only
// - first-limit bits 15-8 are remote 8-1, bit 7 local, 6-0 zero
// - first-limit flag sets when temperature exceeds that channel's limit
// - first-limit flag clears below first limit minus shared hysteresis
// - first alert is low while any channel is over its first limit
// - temperature equal to limit minus hysteresis releases flag and output
// - second-limit flags register at pointer 22h is read-only
// - second-limit bits 15-8 are remote 8-1, bit 7 local, 6-0 zero
// - second-limit flag sets when temperature exceeds its second limit
// - second-limit flag clears below second limit minus shared hysteresis
// - second alert is low while any channel is over its second limit
// - remote open flags register at pointer 23h is read-only
// - open bits 15-8 flag remote 8-1 open circuit; bits 7-0 zero
// - open flags never drive either alert output directly
module tlsf_status_flags (
  input wire logic clock,
  input wire logic rst,
  input wire tlsf_pkg::tlsf_reg_req_t regReq,
  output logic [15:0] regRdata,
  input wire tlsf_pkg::tlsf_conv_t convResult,
  input wire logic [8:0][15:0] firstLimit,
  input wire logic [8:0][15:0] secondLimit,
  input wire logic [15:0] hysteresis,
  input wire logic registerLockOn,
  output logic softResetPulse,
  output logic first_alert_n,
  output logic second_alert_n
);

  logic [8:0] overFirst_reg;
  logic [8:0] overSecond_reg;
  logic [8:1] remoteOpen_reg;
  logic [8:0] overFirst_next;
  logic [8:0] overSecond_next;
  logic [8:1] remoteOpen_next;
  logic [15:0] regRdata_reg;
  logic softResetPulse_reg;
  logic firstAlertN_reg;
  logic secondAlertN_reg;
  logic [8:0] hitVec;
  logic [8:0] firstCmpOver;
  logic [8:0] firstCmpRel;
  logic [8:0] secondCmpOver;
  logic [8:0] secondCmpRel;
  logic [8:0] firstAtRel;
  logic [8:0] secondAtRel;

  // named views of the flag groups
  wire localOverFirstLimit = overFirst_reg[0];
  wire [8:1] remoteOverFirstLimit = overFirst_reg[8:1];
  wire localOverSecondLimit = overSecond_reg[0];
  wire [8:1] remoteOverSecondLimit = overSecond_reg[8:1];
  wire [8:1] remote_diode_open = remoteOpen_reg;

  // register access decode
  wire hitSoft = regReq.pointer == tlsf_pkg::PTR_SOFT_RESET_CONTROL;
  wire hitFirst = regReq.pointer == tlsf_pkg::PTR_FIRST_LIMIT_FLAGS;
  wire hitSecond = regReq.pointer == tlsf_pkg::PTR_SECOND_LIMIT_FLAGS;
  wire hitOpen = regReq.pointer == tlsf_pkg::PTR_REMOTE_OPEN_FLAGS;
  // a locked device drops the reset request before it reaches anything
  wire softTrigger = regReq.wrStrobe && hitSoft &&
    regReq.wdata[tlsf_pkg::SOFT_RESET_BIT] && !registerLockOn;

  // status words; writes to 21h-23h have no path into the flags
  wire [15:0] firstWord = {localFirstPad(overFirst_reg)};
  wire [15:0] secondWord = {localFirstPad(overSecond_reg)};
  wire [15:0] openWord = {remoteOpen_reg, 8'h00};

  // the bit register self-clears, so the whole word always reads zero
  wire [15:0] rdMux =
    hitSoft ? tlsf_pkg::SOFT_RESET_POR :
    hitFirst ? firstWord :
    hitSecond ? secondWord :
    hitOpen ? openWord : tlsf_pkg::UNMAPPED_READ;

  // flags sit above seven zero bits, local at the bottom
  function automatic logic [15:0] localFirstPad(input logic [8:0] f);
    localFirstPad = {f, 7'h00};
  endfunction

  // per-channel comparators and flag next state
  generate
    for (genvar i = 0; i < tlsf_pkg::NUM_CHAN; i++) begin : gChan
      // two guard bits so a low limit minus a large hysteresis cannot wrap
      wire signed [17:0] tempS = {{2{convResult.temp[15]}}, convResult.temp};
      wire signed [17:0] hystS = {2'b00, hysteresis};
      wire signed [17:0] lim1 = {{2{firstLimit[i][15]}}, firstLimit[i]};
      wire signed [17:0] lim2 = {{2{secondLimit[i][15]}}, secondLimit[i]};
      assign hitVec[i] = convResult.valid && convResult.chan == 4'(i);
      assign firstCmpOver[i] = tempS > lim1;
      // equality with limit minus hysteresis already releases
      assign firstCmpRel[i] = tempS <= lim1 - hystS;
      assign secondCmpOver[i] = tempS > lim2;
      assign secondCmpRel[i] = tempS <= lim2 - hystS;
      // exact threshold hits, watched by the release checks below
      assign firstAtRel[i] = tempS == lim1 - hystS;
      assign secondAtRel[i] = tempS == lim2 - hystS;
      // between the two thresholds the flag holds its state
      assign overFirst_next[i] = !hitVec[i] ? overFirst_reg[i] :
        firstCmpOver[i] ? 1'b1 :
        firstCmpRel[i] ? 1'b0 : overFirst_reg[i];
      assign overSecond_next[i] = !hitVec[i] ? overSecond_reg[i] :
        secondCmpOver[i] ? 1'b1 :
        secondCmpRel[i] ? 1'b0 : overSecond_reg[i];
      if (i > 0) begin : gRemote
        assign remoteOpen_next[i] = hitVec[i] ? convResult.open :
          remoteOpen_reg[i];
      end
    end
  endgenerate

  // flags; a soft reset clears them like a power-on
  always_ff @(posedge clock) begin
    if (rst || softTrigger) begin
      overFirst_reg <= '0;
      overSecond_reg <= '0;
      remoteOpen_reg <= '0;
    end else begin
      overFirst_reg <= overFirst_next;
      overSecond_reg <= overSecond_next;
      remoteOpen_reg <= remoteOpen_next;
    end
  end

  // alerts follow the flag next state so they change with the flags;
  // open bits are deliberately absent from these terms
  always_ff @(posedge clock) begin
    if (rst || softTrigger) begin
      firstAlertN_reg <= 1'b1;
      secondAlertN_reg <= 1'b1;
    end else begin
      firstAlertN_reg <= ~|overFirst_next;
      secondAlertN_reg <= ~|overSecond_next;
    end
  end

  // read data is captured on the read strobe and held until the next
  always_ff @(posedge clock) begin
    if (rst) begin
      regRdata_reg <= 16'h0000;
      softResetPulse_reg <= 1'b0;
    end else begin
      if (regReq.rdStrobe) begin
        regRdata_reg <= rdMux;
      end
      softResetPulse_reg <= softTrigger;
    end
  end

  assign regRdata = regRdata_reg;
  assign softResetPulse = softResetPulse_reg;
  assign first_alert_n = firstAlertN_reg;
  assign second_alert_n = secondAlertN_reg;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  wire wrSoftOne = regReq.wrStrobe && hitSoft &&
    regReq.wdata[tlsf_pkg::SOFT_RESET_BIT];
  wire wrStatus = regReq.wrStrobe && (hitFirst || hitSecond || hitOpen);

  AST_SOFT_PULSE: assert property (
    wrSoftOne && !registerLockOn |=> softResetPulse ##1 !softResetPulse
      && overFirst_reg == 9'h000 && first_alert_n)
    else $error("soft reset write did not give one reset pulse");
  AST_LOCK_BLOCKS: assert property (
    wrSoftOne && registerLockOn |=> !softResetPulse)
    else $error("soft reset acted while locked");
  AST_RD_SOFT: assert property (
    regReq.rdStrobe && hitSoft |=> regRdata == 16'h0000)
    else $error("soft reset register read not zero");
  AST_RD_FIRST: assert property (
    regReq.rdStrobe && hitFirst && !convResult.valid |=>
      regRdata == {overFirst_reg, 7'h00})
    else $error("first limit word layout wrong");
  AST_RD_OPEN: assert property (
    regReq.rdStrobe && hitOpen && !convResult.valid |=>
      regRdata[7:0] == 8'h00 && regRdata[15:8] == remoteOpen_reg)
    else $error("open flag word layout wrong");
  AST_WR_STATUS_IGNORED: assert property (
    wrStatus && !convResult.valid |=> $stable(overFirst_reg) &&
      $stable(overSecond_reg) && $stable(remoteOpen_reg))
    else $error("write changed a read-only status register");
  AST_FIRST_SET: assert property (
    |(hitVec & firstCmpOver) && !softTrigger |=>
      (overFirst_reg & $past(hitVec)) != 9'h000)
    else $error("first limit flag not set when over limit");
  AST_FIRST_REL: assert property (
    |(hitVec & firstCmpRel & ~firstCmpOver) |=>
      (overFirst_reg & $past(hitVec)) == 9'h000)
    else $error("first limit flag not released at threshold");
  AST_SECOND_SET: assert property (
    |(hitVec & secondCmpOver) && !softTrigger |=>
      (overSecond_reg & $past(hitVec)) != 9'h000)
    else $error("second limit flag not set when over limit");
  AST_ALERT1: assert property (
    first_alert_n == ~|overFirst_reg)
    else $error("first alert disagrees with first limit flags");
  AST_ALERT2: assert property (
    second_alert_n == ~|overSecond_reg)
    else $error("second alert disagrees with second limit flags");
  AST_OPEN_NO_ALERT: assert property (
    convResult.valid && convResult.open && first_alert_n &&
      !(|(hitVec & firstCmpOver)) && !softTrigger |=> first_alert_n)
    else $error("open circuit drove the first alert");
  AST_SKIP_KEEP: assert property (
    !convResult.valid && !softTrigger |=> $stable(overFirst_reg) &&
      $stable(overSecond_reg) && $stable(remoteOpen_reg))
    else $error("flags moved without a new result");

  // register access: second word layout, reserved bits, unmapped pointers, ignored writes
  AST_RD_SECOND: assert property (
    regReq.rdStrobe && hitSecond && !convResult.valid |=>
      regRdata == {overSecond_reg, 7'h00})
    else $error("second limit word layout wrong");
  AST_RD_FIRST_LOW: assert property (
    regReq.rdStrobe && hitFirst |=> regRdata[6:0] == 7'h00)
    else $error("first limit word reserved bits not zero");
  AST_RD_SECOND_LOW: assert property (
    regReq.rdStrobe && hitSecond |=> regRdata[6:0] == 7'h00)
    else $error("second limit word reserved bits not zero");
  AST_RD_UNMAPPED: assert property (
    regReq.rdStrobe && !(hitSoft || hitFirst || hitSecond || hitOpen) |=>
      regRdata == 16'h0000)
    else $error("unmapped pointer read not zero");
  AST_WR_SECOND_IGNORED: assert property (
    regReq.wrStrobe && hitSecond && !convResult.valid |=>
      $stable(overSecond_reg))
    else $error("write changed the second limit flags");
  AST_WR_OPEN_IGNORED: assert property (
    regReq.wrStrobe && hitOpen && !convResult.valid |=>
      $stable(remoteOpen_reg))
    else $error("write changed the open flags");

  // soft reset: clears every flag, needs a one in the top bit, obeys lock
  AST_SOFT_CLEARS: assert property (
    softTrigger |=> overSecond_reg == 9'h000 &&
      remoteOpen_reg == 8'h00 && second_alert_n)
    else $error("soft reset left flags set");
  AST_ZERO_WRITE: assert property (
    regReq.wrStrobe && hitSoft &&
      !regReq.wdata[tlsf_pkg::SOFT_RESET_BIT] |=> !softResetPulse)
    else $error("zero write to soft reset acted");
  AST_PULSE_SOURCE: assert property (
    !softTrigger |=> !softResetPulse)
    else $error("reset pulse without a soft reset write");
  AST_LOCK_KEEPS: assert property (
    wrSoftOne && registerLockOn && !convResult.valid |=>
      $stable(overFirst_reg) && $stable(overSecond_reg) &&
      $stable(remoteOpen_reg))
    else $error("locked soft reset changed the flags");

  // hysteresis band: release at or below threshold, hold inside the band
  AST_SECOND_REL: assert property (
    |(hitVec & secondCmpRel & ~secondCmpOver) |=>
      (overSecond_reg & $past(hitVec)) == 9'h000)
    else $error("second limit flag not released at threshold");
  AST_FIRST_EQ_REL: assert property (
    |(hitVec & firstAtRel) |=> (overFirst_reg & $past(hitVec)) == 9'h000)
    else $error("first flag held at limit minus hysteresis");
  AST_SECOND_EQ_REL: assert property (
    |(hitVec & secondAtRel) |=> (overSecond_reg & $past(hitVec)) == 9'h000)
    else $error("second flag held at limit minus hysteresis");
  AST_FIRST_HOLD: assert property (
    |(hitVec & ~firstCmpOver & ~firstCmpRel) && !softTrigger |=>
      (overFirst_reg & $past(hitVec)) == ($past(overFirst_reg) & $past(hitVec)))
    else $error("first flag moved inside the hysteresis band");
  AST_SECOND_HOLD: assert property (
    |(hitVec & ~secondCmpOver & ~secondCmpRel) && !softTrigger |=>
      (overSecond_reg & $past(hitVec)) == ($past(overSecond_reg) & $past(hitVec)))
    else $error("second flag moved inside the hysteresis band");

  // alerts seen from each flag group
  AST_ALERT1_LOCAL: assert property (
    localOverFirstLimit |-> !first_alert_n)
    else $error("local over first limit but first alert high");
  AST_ALERT1_REMOTE: assert property (
    |remoteOverFirstLimit |-> !first_alert_n)
    else $error("remote over first limit but first alert high");
  AST_ALERT2_LOCAL: assert property (
    localOverSecondLimit |-> !second_alert_n)
    else $error("local over second limit but second alert high");
  AST_ALERT2_REMOTE: assert property (
    |remoteOverSecondLimit |-> !second_alert_n)
    else $error("remote over second limit but second alert high");
  AST_OPEN_NO_ALERT2: assert property (
    convResult.valid && convResult.open && second_alert_n &&
      !(|(hitVec & secondCmpOver)) && !softTrigger |=> second_alert_n)
    else $error("open circuit drove the second alert");

  // open flags follow each result; bad channel codes touch nothing
  AST_OPEN_FOLLOWS: assert property (
    convResult.valid && |hitVec[8:1] && !softTrigger |=>
      (remote_diode_open & $past(hitVec[8:1])) ==
      ($past(convResult.open) ? $past(hitVec[8:1]) : 8'h00))
    else $error("open flag did not follow the result");
  AST_BAD_CHAN: assert property (
    convResult.valid && convResult.chan > 4'h8 && !softTrigger |=>
      $stable(overFirst_reg) && $stable(overSecond_reg) &&
      $stable(remoteOpen_reg))
    else $error("result for a missing channel changed flags");

  COV_FIRST_TRIP: cover property (
    first_alert_n ##1 !first_alert_n ##[1:20] first_alert_n);
  COV_SECOND_TRIP: cover property (second_alert_n ##1 !second_alert_n);
  COV_OPEN: cover property (|remoteOpen_reg);
  COV_LOCKED_RESET: cover property (wrSoftOne && registerLockOn);
  COV_SOFT_RESET: cover property (softTrigger ##1 softResetPulse);
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
// self-checking bench for the limit status flags block
// assumes the host model owns the register port; bench drives the rest
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  tlsf_pkg::tlsf_reg_req_t regReq;
  tlsf_pkg::tlsf_conv_t convResult = '0;
  logic [8:0][15:0] firstLimit = {9{16'h0500}};
  logic [8:0][15:0] secondLimit = {9{16'h0800}};
  logic [15:0] hysteresis = 16'h0100;
  logic registerLockOn = 1'b0;
  logic [15:0] regRdata;
  logic softResetPulse, first_alert_n, second_alert_n;
  logic [15:0] exp;
  int err_total = 0;
  int n_compared = 0;
  always #2 clock = ~clock;
  tlsf_status_flags u_dut (.clock(clock), .rst(rst), .regReq(regReq),
    .regRdata(regRdata), .convResult(convResult), .firstLimit(firstLimit),
    .secondLimit(secondLimit), .hysteresis(hysteresis),
    .registerLockOn(registerLockOn), .softResetPulse(softResetPulse),
    .first_alert_n(first_alert_n), .second_alert_n(second_alert_n));
  tlsf_host_model u_host (.clock(clock), .regReq(regReq),
    .regRdata(regRdata));
  task automatic chk(input logic [15:0] seen, input logic [15:0] want);
    n_compared++;
    if (seen !== want) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [15:0] want);
    logic [15:0] d;
    u_host.xfer(1'b0, ptr, 16'h0000, d);
    chk(d, want);
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [15:0] wd);
    logic [15:0] d;
    u_host.xfer(1'b1, ptr, wd, d);
  endtask
  // alert pair as one value: bit1 first, bit0 second
  task automatic al(input logic [15:0] want);
    chk({14'h0000, first_alert_n, second_alert_n}, want);
  endtask
  // one stored result; released fields are inverted, not held
  task automatic cv(input logic [3:0] ch, input logic [15:0] t,
    input logic op);
    @(posedge clock);
    convResult <= '{1'b1, ch, t, op};
    @(posedge clock);
    convResult <= '{1'b0, ~ch, ~t, ~op};
    #1;
  endtask
  task automatic t_reset;
    rd(8'h20, 16'h0000);
    rd(8'h21, 16'h0000);
    rd(8'h22, 16'h0000);
    rd(8'h23, 16'h0000);
    rd(8'h55, 16'h0000);
    al(16'h0003);
    $display("test reset done");
  endtask
  task automatic t_hyst;
    cv(4'h3, 16'h0500, 1'b0);
    rd(8'h21, 16'h0000);
    cv(4'h3, 16'h0508, 1'b0);
    al(16'h0001);
    rd(8'h21, 16'h0400);
    cv(4'h3, 16'h0408, 1'b0);
    rd(8'h21, 16'h0400);
    cv(4'h3, 16'h0808, 1'b0);
    al(16'h0000);
    rd(8'h22, 16'h0400);
    cv(4'h3, 16'h0700, 1'b0);
    rd(8'h22, 16'h0000);
    al(16'h0001);
    cv(4'h3, 16'h0400, 1'b0);
    al(16'h0003);
    rd(8'h21, 16'h0000);
    $display("test hysteresis done");
  endtask
  task automatic t_map;
    exp = 16'h0000;
    for (int ch = 0; ch < 9; ch++) begin
      cv(ch[3:0], 16'h0600, 1'b0);
      exp = exp | (16'h0080 << ch);
      rd(8'h21, exp);
    end
    wr(8'h21, 16'hFFFF);
    wr(8'h22, 16'hFFFF);
    rd(8'h21, 16'hFF80);
    rd(8'h22, 16'h0000);
    $display("test channel map done");
  endtask
  task automatic t_srst;
    @(posedge clock);
    registerLockOn <= 1'b1;
    wr(8'h20, 16'h8000);
    chk({15'h0000, softResetPulse}, 16'h0000);
    rd(8'h21, 16'hFF80);
    @(posedge clock);
    registerLockOn <= 1'b0;
    wr(8'h20, 16'h0000);
    chk({15'h0000, softResetPulse}, 16'h0000);
    wr(8'h20, 16'h8000);
    chk({15'h0000, softResetPulse}, 16'h0001);
    @(posedge clock);
    #1 chk({15'h0000, softResetPulse}, 16'h0000);
    al(16'h0003);
    rd(8'h21, 16'h0000);
    rd(8'h20, 16'h0000);
    $display("test soft reset done");
  endtask
  task automatic t_open;
    cv(4'h8, 16'h0000, 1'b1);
    al(16'h0003);
    rd(8'h23, 16'h8000);
    cv(4'h0, 16'h0000, 1'b1);
    cv(4'h9, 16'h0F00, 1'b1);
    al(16'h0003);
    rd(8'h23, 16'h8000);
    wr(8'h23, 16'hFFFF);
    rd(8'h23, 16'h8000);
    cv(4'h8, 16'h0000, 1'b0);
    rd(8'h23, 16'h0000);
    $display("test open circuit done");
  endtask
  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    final_report;
  end
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    t_reset;
    t_hyst;
    t_map;
    t_srst;
    t_open;
    final_report;
  end
endmodule
`default_nettype wire

// ---- verification/tlsf_host_model.sv ----
// host-side model of the register strobe port
// assumes the bench calls xfer from a process on the device clock
`default_nettype none
module tlsf_host_model (
  input wire logic clock,
  output var tlsf_pkg::tlsf_reg_req_t regReq,
  input wire logic [15:0] regRdata
);
  initial regReq = '0;
  // one whole word per access; released lines carry inverted values so
  // that stale pointer or data never looks like a live request
  task automatic xfer(input logic wr, input logic [7:0] ptr,
    input logic [15:0] wd, output logic [15:0] rd);
    @(posedge clock);
    regReq <= '{wr, ~wr, ptr, wd};
    @(posedge clock);
    regReq <= '{1'b0, 1'b0, ~ptr, ~wd};
    #1 rd = regRdata; // answer one cycle after
  endtask
endmodule
`default_nettype wire
